// File: src/kbfi_keypad.sv
// port-F keypad interrupt: pin sync, request latch, registers and checks
//
// Overview of operation
// - one interrupt enable bit per pin, each pin independent
// - interrupt enable never turns on a pull-up; separate pull-up bits do
// - pull-up bits reset to ones; writing zero disables that pull-up
// - latch a request when enabled pins go low after all were high
// - edge mode: no new request while another enabled pin is low
// - level mode: request held while any enabled pin is low
// - level mode: clear needs acknowledge and all pins high, any order
// - vector fetch acknowledges and clears the request per mode
// - writing one to acknowledge bit acknowledges; it reads as zero
// - a falling edge after acknowledge latches a fresh request
// - unmasked request is taken through vector FFE8 and FFE9
// - edge mode: acknowledge clears the request at once
// - reset clears request and trigger mode even with a pin low
// - read-only pending flag shows the latch regardless of mask
// - mask bit one blocks forwarding, zero allows; reset clears it
// - interrupt enable forces the pin to act as an input
// - status bits 7:4 read as zero
// - trigger select one is edge and level, zero is edge only
// - keeps running in low-power modes; unmasked request wakes the cpu
// - in break with clear allowed, software acknowledge clears for good
// - in break with clear not allowed, acknowledge writes do nothing
//
// The address map and the address-and-strobe port were decided locally.
module kbfi_keypad
   import kbfi_pkg::*;
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // register port
   input  wire kbfi_pkg::kbfi_bus_req_t busReq,
   output logic [7:0]                 busRdata,
   // keypad pins and port logic
   input  wire logic [7:0]            pinIn,
   input  wire logic [7:0]            portDirectionBits,
   output logic [7:0]                 portDirEffective,
   output logic [7:0]                 pinPullupOn,
   // cpu and system side
   input  wire logic                  vectorFetch,
   input  wire logic                  breakState,
   input  wire logic                  breakClearAllow,
   output logic                       irqRequest,
   output logic                       wakeRequest,
   output logic [15:0]                irqVectorHi,
   output logic [15:0]                irqVectorLo,
   output logic                       ackPulse
);

   import kbfi_pkg::*;

   kbfi_state_t state_q;
   kbfi_state_t state_d;

   logic [7:0]  enabledLow;
   logic        anyLow;
   logic        fallEvent;
   logic        swAck;
   logic        ackNow;
   logic        wrStatus;
   logic        wrIrqEn;
   logic        wrPullup;
   logic [7:0]  statusView;
   logic        forwardReq;

   // shared decode of one register offset
   function automatic logic hitReg(input logic [1:0] addr,
                                   input logic [1:0] ofs);
      hitReg = (addr == ofs);
   endfunction : hitReg

   always_comb begin
      wrStatus = busReq.wr && hitReg(busReq.addr, OFS_STATUS_CTRL);
      wrIrqEn  = busReq.wr && hitReg(busReq.addr, OFS_PIN_IRQ_EN);
      wrPullup = busReq.wr && hitReg(busReq.addr, OFS_PULLUP_EN);
   end

   // only the filtered level is looked at; raw sync stages stay private
   always_comb begin
      enabledLow = ~state_q.pinLevel & state_q.pinIrqEnableBits;
      anyLow     = |enabledLow;
      // all enabled high last cycle, at least one low now
      fallEvent  = anyLow && !state_q.prevAnyLow;
   end

   // break protection applies to software acknowledge only
   always_comb begin
      swAck  = wrStatus && busReq.wdata[BIT_ACK]
               && !(breakState && !breakClearAllow);
      ackNow = swAck || vectorFetch;
   end

   always_comb begin
      statusView = {STATUS_HI_ZERO,
                    state_q.latched,
                    1'b0,
                    state_q.irqMask,
                    (state_q.trigLevelSelect == TRIG_EDGE_LEVEL)};
   end

   always_comb begin
      state_d = state_q;

      // three stages, a change counts once the last two agree
      state_d.syncA = pinIn;
      state_d.syncB = state_q.syncA;
      state_d.syncC = state_q.syncB;
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (state_q.syncB[i] == state_q.syncC[i]) begin
            state_d.pinLevel[i] = state_q.syncC[i];
         end
      end
      state_d.prevAnyLow = anyLow;

      case (state_q.trigLevelSelect)
         TRIG_EDGE_ONLY: begin
            state_d.ackSeen = 1'b0;
            if (fallEvent) begin
               // set wins over a clear in the same cycle
               state_d.latched = 1'b1;
            end else if (ackNow) begin
               state_d.latched = 1'b0;
            end
         end
         TRIG_EDGE_LEVEL: begin
            if (fallEvent) begin
               // a new edge needs its own acknowledge
               state_d.latched = 1'b1;
               state_d.ackSeen = 1'b0;
            end else if (anyLow) begin
               state_d.latched = 1'b1;
               if (ackNow) begin
                  state_d.ackSeen = 1'b1;
               end
            end else if (ackNow || state_q.ackSeen) begin
               state_d.latched = 1'b0;
               state_d.ackSeen = 1'b0;
            end
         end
         default: begin
            state_d.latched = 1'b0;
            state_d.ackSeen = 1'b0;
         end
      endcase

      if (wrStatus) begin
         state_d.irqMask = busReq.wdata[BIT_MASK];
         state_d.trigLevelSelect = busReq.wdata[BIT_LEVEL_SEL] ?
                                   TRIG_EDGE_LEVEL : TRIG_EDGE_ONLY;
      end
      if (wrIrqEn) begin
         state_d.pinIrqEnableBits = busReq.wdata;
      end
      if (wrPullup) begin
         state_d.pinPullupEnableBits = busReq.wdata;
      end

      // read data stands one cycle, zero otherwise
      state_d.readData = RST_READ_DATA;
      if (busReq.rd) begin
         case (busReq.addr)
            OFS_STATUS_CTRL: state_d.readData = statusView;
            OFS_PIN_IRQ_EN:  state_d.readData = state_q.pinIrqEnableBits;
            OFS_PULLUP_EN:   state_d.readData = state_q.pinPullupEnableBits;
            default:         state_d.readData = RST_READ_DATA;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q.syncA               <= RST_PIN_SYNC;
         state_q.syncB               <= RST_PIN_SYNC;
         state_q.syncC               <= RST_PIN_SYNC;
         state_q.pinLevel            <= RST_PIN_SYNC;
         state_q.prevAnyLow          <= 1'b0;
         state_q.latched             <= 1'b0;
         state_q.ackSeen             <= 1'b0;
         state_q.trigLevelSelect     <= TRIG_EDGE_ONLY;
         state_q.irqMask             <= 1'b0;
         state_q.pinIrqEnableBits    <= RST_PIN_IRQ_EN;
         state_q.pinPullupEnableBits <= RST_PULLUP_EN;
         state_q.readData            <= RST_READ_DATA;
      end else begin
         state_q <= state_d;
      end
   end

   // outputs
   always_comb begin
      busRdata         = state_q.readData;
      // pull-ups follow their own bits only, never the enables
      pinPullupOn      = state_q.pinPullupEnableBits;
      portDirEffective = portDirectionBits
                         & ~state_q.pinIrqEnableBits;
      // one forwarding term feeds both interrupt and wake
      forwardReq       = state_q.latched && !state_q.irqMask;
      irqRequest       = forwardReq;
      // no clock gating here, so wake simply mirrors the request
      wakeRequest      = forwardReq;
      irqVectorHi      = VEC_ADDR_HI;
      irqVectorLo      = VEC_ADDR_LO;
      ackPulse         = ackNow;
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic levelMode;
   assign levelMode = (state_q.trigLevelSelect == TRIG_EDGE_LEVEL);

   a_edge_sets_latch: assert property (
      fallEvent |=> state_q.latched)
      else $error("falling edge did not latch a request");

   a_edge_blocked_low: assert property (
      (!levelMode && state_q.prevAnyLow && !ackNow && !state_q.latched)
      |=> !state_q.latched)
      else $error("request latched while a pin was already low");

   a_level_holds_req: assert property (
      (levelMode && anyLow) |=> state_q.latched)
      else $error("level mode dropped request while a pin is low");

   a_level_ack_order: assert property (
      (levelMode && state_q.ackSeen && !anyLow && !fallEvent)
      |=> !state_q.latched)
      else $error("acknowledge before pins high did not clear later");

   a_level_no_ack: assert property (
      (levelMode && state_q.latched && !ackNow && !state_q.ackSeen)
      |=> state_q.latched)
      else $error("level mode request cleared without acknowledge");

   a_edge_ack_clears: assert property (
      (!levelMode && ackNow && !fallEvent) |=> !state_q.latched)
      else $error("edge mode acknowledge did not clear at once");

   a_ack_reads_zero: assert property (
      (busReq.rd && busReq.addr == OFS_STATUS_CTRL)
      |=> (busRdata[BIT_ACK] == 1'b0 && busRdata[7:4] == 4'h0))
      else $error("acknowledge or unused bits read nonzero");

   a_pending_flag: assert property (
      (busReq.rd && busReq.addr == OFS_STATUS_CTRL)
      |=> busRdata[BIT_PENDING] == $past(state_q.latched))
      else $error("pending flag differs from latch");

   a_mask_gates_irq: assert property (
      irqRequest == (state_q.latched && !state_q.irqMask))
      else $error("interrupt output not gated by mask");

   a_break_protect: assert property (
      (!levelMode && breakState && !breakClearAllow && !vectorFetch
       && state_q.latched) |=> state_q.latched)
      else $error("acknowledge cleared latch while protected");

   a_input_forced: assert property (
      (portDirEffective & state_q.pinIrqEnableBits) == 8'h00)
      else $error("enabled pin left as output");

   a_sync_delay: assert property (
      ($changed(pinIn) ##1 $stable(pinIn) [*4])
      |-> state_q.pinLevel == pinIn)
      else $error("filtered pin level not settled after four cycles");

   // register writes land one cycle later
   a_enable_write: assert property (
      wrIrqEn
      |=> state_q.pinIrqEnableBits == $past(busReq.wdata))
      else $error("interrupt enable write did not land");

   a_pullup_write: assert property (
      wrPullup
      |=> pinPullupOn == $past(busReq.wdata))
      else $error("pull-up enable write did not land");

   a_pullup_indep: assert property (
      wrIrqEn
      |=> $stable(pinPullupOn))
      else $error("interrupt enable write moved a pull-up");

   a_mask_write: assert property (
      wrStatus
      |=> state_q.irqMask == $past(busReq.wdata[BIT_MASK]))
      else $error("mask write did not land");

   a_mode_write: assert property (
      wrStatus
      |=> levelMode == $past(busReq.wdata[BIT_LEVEL_SEL]))
      else $error("trigger select write did not land");

   a_mask_blocks: assert property (
      (wrStatus && busReq.wdata[BIT_MASK])
      |=> (!irqRequest && !wakeRequest))
      else $error("masked request still forwarded");

   // acknowledge and break protection
   a_ack_pulse_sw: assert property (
      (wrStatus && busReq.wdata[BIT_ACK] && !breakState)
      |-> ackPulse)
      else $error("software acknowledge gave no pulse");

   a_vector_ack: assert property (
      vectorFetch
      |-> ackPulse)
      else $error("vector fetch gave no acknowledge");

   a_break_allowed: assert property (
      (!levelMode && breakState && breakClearAllow && wrStatus && busReq.wdata[BIT_ACK] && !fallEvent)
      |=> !state_q.latched)
      else $error("allowed acknowledge in break did not clear");

   a_break_level_hold: assert property (
      (levelMode && breakState && !breakClearAllow && !vectorFetch && !state_q.ackSeen && state_q.latched)
      |=> state_q.latched)
      else $error("level request cleared while protected");

   a_level_ack_high: assert property (
      (levelMode && ackNow && !anyLow && !fallEvent)
      |=> !state_q.latched)
      else $error("acknowledge with pins high did not clear");

   a_level_fall_ack: assert property (
      (levelMode && fallEvent)
      |=> !state_q.ackSeen)
      else $error("new edge kept an old acknowledge");

   a_no_spurious: assert property (
      (!fallEvent && !state_q.latched && !(levelMode && anyLow))
      |=> !state_q.latched)
      else $error("request latched without a falling edge");

   a_edge_latch_stands: assert property (
      (!levelMode && state_q.latched && !ackNow)
      |=> state_q.latched)
      else $error("edge mode request dropped without acknowledge");

   a_pending_masked: assert property (
      (busReq.rd && busReq.addr == OFS_STATUS_CTRL && state_q.irqMask && state_q.latched)
      |=> busRdata[BIT_PENDING])
      else $error("pending flag hidden by mask");

   a_wake_on_edge: assert property (
      (fallEvent && !state_q.irqMask && !wrStatus)
      |=> wakeRequest)
      else $error("unmasked edge did not raise wake");

   // reset and pin path
   a_reset_clears: assert property (
      @(posedge clock) disable iff (1'b0)
      (!rst_n ##1 !rst_n)
      |-> (!state_q.latched && !levelMode && !irqRequest && !state_q.irqMask))
      else $error("reset left a request or mode set");

   a_dir_passes: assert property (
      ((portDirEffective ^ portDirectionBits) & ~state_q.pinIrqEnableBits)
      == 8'h00)
      else $error("direction of a plain pin was altered");

   a_filter_agree: assert property (
      (state_q.syncB == state_q.syncC)
      |=> state_q.pinLevel == $past(state_q.syncC))
      else $error("agreeing sync stages not taken as level");

   c_edge_ack: cover property (
      fallEvent ##[1:20] (ackNow && !levelMode));
   c_level_both: cover property (
      levelMode && anyLow && ackNow ##[1:20] !state_q.latched);
   c_break_write: cover property (
      breakState && wrStatus && busReq.wdata[BIT_ACK]);
   c_wake: cover property (
      $rose(wakeRequest));
   c_level_ack_first: cover property (
      levelMode && state_q.ackSeen ##1 !state_q.latched);

endmodule : kbfi_keypad

// File: src/kbfi_pkg.sv
// package: register map, field layout and reset values of the port-F keypad interrupt
package kbfi_pkg;

   localparam int          PIN_COUNT       = 8;
   localparam int          REG_ADDR_W      = 2;

   // register offsets
   localparam logic [1:0]  OFS_STATUS_CTRL = 2'h0;
   localparam logic [1:0]  OFS_PIN_IRQ_EN  = 2'h1;
   localparam logic [1:0]  OFS_PULLUP_EN   = 2'h2;

   // status and control field positions
   localparam int          BIT_PENDING     = 3;
   localparam int          BIT_ACK         = 2;
   localparam int          BIT_MASK        = 1;
   localparam int          BIT_LEVEL_SEL   = 0;

   // values after reset
   localparam logic [7:0]  RST_PIN_IRQ_EN  = 8'h00;
   localparam logic [7:0]  RST_PULLUP_EN   = 8'hFF;
   localparam logic [7:0]  RST_PIN_SYNC    = 8'hFF;
   localparam logic [7:0]  RST_READ_DATA   = 8'h00;
   localparam logic [3:0]  STATUS_HI_ZERO  = 4'h0;

   // interrupt vector locations
   localparam logic [15:0] VEC_ADDR_HI     = 16'hFFE8;
   localparam logic [15:0] VEC_ADDR_LO     = 16'hFFE9;

   typedef enum logic {
      TRIG_EDGE_ONLY,
      TRIG_EDGE_LEVEL
   } kbfi_trig_t;

   // register bus request
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } kbfi_bus_req_t;

   // complete module state
   typedef struct packed {
      logic [7:0] syncA;
      logic [7:0] syncB;
      logic [7:0] syncC;
      logic [7:0] pinLevel;
      logic       prevAnyLow;
      logic       latched;
      logic       ackSeen;
      kbfi_trig_t trigLevelSelect;
      logic       irqMask;
      logic [7:0] pinIrqEnableBits;
      logic [7:0] pinPullupEnableBits;
      logic [7:0] readData;
   } kbfi_state_t;

endpackage : kbfi_pkg

// File: dv/kbfi_keypad_switches.sv
// keypad switch model: pressed keys pull pins low, pull-ups lift idle pins
module kbfi_keypad_switches (
   // clock
   input  wire logic       clock,
   // key and pull-up state
   input  wire logic [7:0] pressed,
   input  wire logic [7:0] pullupOn,
   // pins
   output logic      [7:0] pinOut
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] floatQ = 8'h00;
   // an idle pin without pull-up holds no level, so it wanders
   always @(posedge clock) floatQ <= ~floatQ;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pinOut[i] = pressed[i] ? 1'b0 : (pullupOn[i] ? 1'b1 : floatQ[i]);
      end
   end
endmodule : kbfi_keypad_switches

// File: dv/kbfi_keypad_bench.sv
// self-checking bench for the keypad interrupt block
module kbfi_keypad_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import kbfi_pkg::*;
   logic          clock = 1'b0;
   logic          rst_n = 1'b0;
   kbfi_bus_req_t busReq = '0;
   logic [7:0]    busRdata, pinIn, dirEff, pullOn, r, d, e;
   logic [7:0]    dir = 8'h00;
   logic [7:0]    pressed = 8'h00;
   logic          vectorFetch = 1'b0;
   logic          breakState = 1'b0;
   logic          breakClearAllow = 1'b0;
   logic          irqRequest, wakeRequest, ackPulse;
   logic [15:0]   vecHi, vecLo;
   int            n_mismatch = 0;
   int            checked = 0;
   int            cycles = 0;
   int            seed = 32'hbf737e02;

   always #25 clock = ~clock;

   kbfi_keypad kbfi_keypad_i (.clock(clock), .rst_n(rst_n), .busReq(busReq),
      .busRdata(busRdata), .pinIn(pinIn), .portDirectionBits(dir),
      .portDirEffective(dirEff), .pinPullupOn(pullOn), .vectorFetch(vectorFetch),
      .breakState(breakState), .breakClearAllow(breakClearAllow),
      .irqRequest(irqRequest), .wakeRequest(wakeRequest), .irqVectorHi(vecHi),
      .irqVectorLo(vecLo), .ackPulse(ackPulse));

   kbfi_keypad_switches kbfi_keypad_switches_i (.clock(clock), .pressed(pressed),
      .pullupOn(pullOn), .pinOut(pinIn));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // generous ceiling: the sequence needs well under 2000 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("ERROR %0t: run timed out", $time);
         tally_and_finish;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clock);
      busReq <= '{a, v, 1'b1, 1'b0};
      @(posedge clock);
      busReq.wr <= 1'b0;
   endtask : wr

   task automatic rdReg(input logic [1:0] a, output logic [7:0] v);
      @(posedge clock);
      busReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      busReq.rd <= 1'b0;
      #1 v = busRdata;
   endtask : rdReg

   function automatic logic [7:0] expSt(input logic p, input logic m, input logic l);
      return {STATUS_HI_ZERO, p, 1'b0, m, l};
   endfunction : expSt

   task automatic st(input logic p, input logic m, input logic l);
      logic [7:0] v;
      rdReg(OFS_STATUS_CTRL, v);
      chk(v, expSt(p, m, l));
   endtask : st

   // key change needs the three sync stages, the filter stage and one more cycle to reach the latch
   task automatic press(input logic [7:0] m);
      @(posedge clock);
      pressed <= m;
      repeat (8) @(posedge clock);
   endtask : press

   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      st(0, 0, 0);
      rdReg(OFS_PIN_IRQ_EN, r);
      chk(r, RST_PIN_IRQ_EN);
      rdReg(OFS_PULLUP_EN, r);
      chk(r, RST_PULLUP_EN);
      rdReg(2'h3, r);
      chk(r, 8'h00);
      chk(vecHi, VEC_ADDR_HI);
      chk(vecLo, VEC_ADDR_LO);
      $display("test reset values done");
      for (int i = 0; i < 10; i++) begin
         d = 8'($random(seed));
         wr(OFS_PULLUP_EN, d);
         rdReg(OFS_PULLUP_EN, r);
         chk(r, d);
         chk(pullOn, d);
      end
      wr(OFS_PULLUP_EN, 8'hFF);
      for (int i = 0; i < 10; i++) begin
         d = 8'($random(seed));
         e = 8'($random(seed));
         dir <= e;
         wr(OFS_PIN_IRQ_EN, d);
         wr(OFS_STATUS_CTRL, e);
         rdReg(OFS_PIN_IRQ_EN, r);
         chk(r, d);
         chk(dirEff, e & ~d);
         chk(pullOn, 8'hFF);
         st(0, e[1], e[0]);
      end
      $display("test register traffic done");
      wr(OFS_STATUS_CTRL, 8'h02);
      dir <= 8'hFF;
      wr(OFS_PIN_IRQ_EN, 8'h03);
      wr(OFS_STATUS_CTRL, 8'h06);
      wr(OFS_STATUS_CTRL, 8'h00);
      press(8'h01);
      st(1, 0, 0);
      chk(irqRequest, 1'b1);
      chk(wakeRequest, 1'b1);
      wr(OFS_STATUS_CTRL, 8'h02);
      st(1, 1, 0);
      chk(irqRequest, 1'b0);
      wr(OFS_STATUS_CTRL, 8'h04);
      st(0, 0, 0);
      press(8'h03);
      st(0, 0, 0);
      press(8'h00);
      press(8'h02);
      st(1, 0, 0);
      @(posedge clock);
      vectorFetch <= 1'b1;
      #1 chk(ackPulse, 1'b1);
      @(posedge clock);
      vectorFetch <= 1'b0;
      press(8'h00);
      st(0, 0, 0);
      $display("test edge mode done");
      press(8'h01);
      breakState <= 1'b1;
      wr(OFS_STATUS_CTRL, 8'h04);
      st(1, 0, 0);
      breakClearAllow <= 1'b1;
      wr(OFS_STATUS_CTRL, 8'h04);
      breakState <= 1'b0;
      press(8'h01);
      st(0, 0, 0);
      press(8'h00);
      $display("test break protection done");
      wr(OFS_STATUS_CTRL, 8'h01);
      press(8'h02);
      st(1, 0, 1);
      wr(OFS_STATUS_CTRL, 8'h05);
      st(1, 0, 1);
      press(8'h00);
      st(0, 0, 1);
      press(8'h02);
      press(8'h00);
      st(1, 0, 1);
      wr(OFS_STATUS_CTRL, 8'h05);
      st(0, 0, 1);
      $display("test level mode done");
      press(8'h01);
      st(1, 0, 1);
      rst_n <= 1'b0;
      #1 chk(irqRequest, 1'b0);
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      st(0, 0, 0);
      $display("test reset with key held done");
      tally_and_finish;
   end
endmodule : kbfi_keypad_bench
